//--- rtl/ldp_top.sv
// lighting dimming pwm controller core with axi4-lite register access
// Function
// - all timing comes from the one core clock
// - 16-bit colour results are copied whole into one register per channel
// - dimmer level becomes a 10-bit code, zero means full dimming
// - converter range picked from the high-voltage supply level
// - analog auxiliary input scales the dimming level as a multiplier
// - auxiliary read as digital level when flash or expander selects it
// - daylight regulation only with sensor detected and enable pin high
// - lux-ceiling input quantised into off, 100, 250, 500, 1000 lux
// - non-off ceiling ignored unless daylight regulation is active
// - ceiling off: after dimmer movement open loop, measure, adopt as target
// - ceiling on: target is dimmer percentage of ceiling maximum
// - sync pin held high by pull-up means synchronisation disabled
// - sync pin low over 100 ms gives full reset, shorter is sync
// - outputs form three pwms, two pwms plus analog, or two pwms
// - each pwm has 12-bit duty at 888 Hz
// - common frequency, staggered turn-on edges so no two outputs rise together
// - first output gives analog or pwm dimming by mode
// - second and third pwms drive cool and warm strings, auto identified
// - strapped mode decoded: 0 analog plus two, 1 three pwms, 2 tuning
// - indicator blinks during programming, steady on when finished
// - setup is loaded from external flash before outputs run
// - maintenance switches read through expanders when fitted, else flash
`default_nettype none
module ldp_top
	import ldp_pkg::*;
#(
	parameter int unsigned RESET_HOLD_CYC = SYNC_RESET_CYC,
	parameter int unsigned LOOP_OPEN_LEN  = LOOP_OPEN_CYC,
	parameter int unsigned BLINK_HALF_LEN = BLINK_HALF_CYC
)(
	input  wire logic        CORE_CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic [7:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output var  logic        S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output var  logic        S_AXI_WREADY_O,
	output var  logic [1:0]  S_AXI_BRESP_O,
	output var  logic        S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [7:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output var  logic        S_AXI_ARREADY_O,
	output var  logic [31:0] S_AXI_RDATA_O,
	output var  logic [1:0]  S_AXI_RRESP_O,
	output var  logic        S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	input  wire logic [11:0] DIMMER_LEVEL_ADC_I,
	input  wire logic        HIGH_VOLTAGE_SUPPLY_HIGH_I,
	output var  logic        DIM_RANGE_HIGH_O,
	input  wire logic [11:0] AUX_ADC_I,
	input  wire logic        AUX_LEVEL_I,
	input  wire logic        EXPANDER_PRESENT_I,
	input  wire logic        EXPANDER_AUX_DIG_I,
	input  wire logic [1:0]  EXPANDER_MAINT_I,
	output var  logic        MAINT_LUMEN_O,
	output var  logic        MAINT_CCT_O,
	input  wire logic        ALS_DETECTED_I,
	input  wire logic        DAYLIGHT_ENABLE_PIN_I,
	input  wire logic [7:0]  LUX_CEILING_INPUT_I,
	input  wire logic [15:0] LUX_MEAS_I,
	output var  logic        DAYLIGHT_ACTIVE_O,
	output var  logic        LOOP_OPEN_O,
	output var  logic [15:0] LUX_TARGET_O,
	input  wire logic        SENSOR_DONE_I,
	input  wire logic [1:0]  SENSOR_CH_I,
	input  wire logic [15:0] SENSOR_RESULT_I,
	input  wire logic        SYNC_OR_RESET_PIN_I,
	output var  logic        FULL_RESET_O,
	input  wire logic [1:0]  MODE_STRAP_I,
	input  wire logic        CONFIG_LOADED_I,
	input  wire logic        PROG_ACTIVE_I,
	input  wire logic        PROG_DONE_I,
	output var  logic        PROGRESS_INDICATOR_OUTPUT_O,
	output var  logic        PWM1_O,
	output var  logic        PWM2_O,
	output var  logic        PWM3_O,
	output var  logic [11:0] ANALOG_DIM_O
);
	// a*b/1024 with a 10-bit result
	function automatic logic [9:0] scale10(input logic [9:0] a, input logic [10:0] b);
		logic [20:0] p;
		p = {11'h000, a} * {10'h000, b};
		scale10 = p[19:10];
	endfunction

	function automatic logic [11:0] duty_of(input logic [9:0] c);
		duty_of = {c, c[9:8]};
	endfunction

	function automatic logic [11:0] mix12(input logic [11:0] a, input logic [11:0] b);
		logic [23:0] p;
		p = {12'h000, a} * {12'h000, b};
		mix12 = p[23:12];
	endfunction

	// sync pin watcher sits on the pin reset only, so its own reset pulse cannot clear it
	logic [24:0] low_cnt_ff;
	logic        full_rst_ff;
	logic        pin_d_ff;
	logic        sync_seen_ff;
	logic        sync_edge_ff;
	logic        core_rst_n;
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			low_cnt_ff   <= 25'h0000000;
			full_rst_ff  <= 1'b0;
			pin_d_ff     <= 1'b1;
			sync_seen_ff <= 1'b0;
			sync_edge_ff <= 1'b0;
		end else begin
			pin_d_ff     <= SYNC_OR_RESET_PIN_I;
			sync_edge_ff <= 1'b0;
			full_rst_ff  <= 1'b0;
			if (!SYNC_OR_RESET_PIN_I) begin
				if (low_cnt_ff < 25'(RESET_HOLD_CYC))
					low_cnt_ff <= low_cnt_ff + 25'h0000001;
				else
					full_rst_ff <= 1'b1;
			end else begin
				low_cnt_ff <= 25'h0000000;
				// short low pulse ending counts as sync, open pin never pulses
				if (!pin_d_ff && low_cnt_ff < 25'(RESET_HOLD_CYC)) begin
					sync_seen_ff <= 1'b1;
					sync_edge_ff <= 1'b1;
				end
			end
			if (full_rst_ff)
				sync_seen_ff <= 1'b0;
		end
	end
	assign core_rst_n   = RESETN_I & ~full_rst_ff;
	assign FULL_RESET_O = full_rst_ff;

	// register file
	logic [4:0]  ctrl_ff;
	logic [11:0] cct_mix_ff;
	logic [15:0] sens_ff [0:2];
	logic [1:0]  mode_ff;
	logic        strap_done_ff;
	logic        range_hi_ff;
	logic [9:0]  dim_code_ff;
	logic [9:0]  aux_code_ff;
	logic [9:0]  eff_dim_ff;
	logic        day_act_ff;
	logic [2:0]  ceil_sel_ff;
	logic        cool_is_2_ff;
	ldp_id_e     id_st_ff;
	logic [15:0] lux_tgt_ff;

	// axi write channel
	logic [7:0]  aw_addr_ff;
	logic        aw_hold_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        w_hold_ff;
	logic        wr_fire;
	assign S_AXI_AWREADY_O = !aw_hold_ff;
	assign S_AXI_WREADY_O  = !w_hold_ff;
	assign wr_fire         = aw_hold_ff && w_hold_ff && !S_AXI_BVALID_O;
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			aw_addr_ff     <= 8'h00;
			aw_hold_ff     <= 1'b0;
			w_data_ff      <= 32'h00000000;
			w_strb_ff      <= 4'h0;
			w_hold_ff      <= 1'b0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O  <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_I && !aw_hold_ff) begin
				aw_addr_ff <= S_AXI_AWADDR_I;
				aw_hold_ff <= 1'b1;
			end
			if (S_AXI_WVALID_I && !w_hold_ff) begin
				w_data_ff <= S_AXI_WDATA_I;
				w_strb_ff <= S_AXI_WSTRB_I;
				w_hold_ff <= 1'b1;
			end
			if (wr_fire) begin
				aw_hold_ff     <= 1'b0;
				w_hold_ff      <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O  <= (aw_addr_ff == REG_CTRL || aw_addr_ff == REG_CCT_MIX) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			ctrl_ff    <= CTRL_RESET;
			cct_mix_ff <= CCT_MIX_RESET;
		end else begin
			ctrl_ff[CTRL_ID_START] <= 1'b0;
			if (wr_fire && aw_addr_ff == REG_CTRL && w_strb_ff[0])
				ctrl_ff <= w_data_ff[4:0];
			if (wr_fire && aw_addr_ff == REG_CCT_MIX) begin
				if (w_strb_ff[0])
					cct_mix_ff[7:0] <= w_data_ff[7:0];
				if (w_strb_ff[1])
					cct_mix_ff[11:8] <= w_data_ff[11:8];
			end
		end
	end

	// axi read channel
	logic [31:0] rd_word;
	logic        rd_ok;
	always_comb begin
		rd_ok   = 1'b1;
		rd_word = 32'h00000000;
		if (S_AXI_ARADDR_I == REG_CTRL)
			rd_word = {27'h0000000, ctrl_ff};
		else if (S_AXI_ARADDR_I == REG_CCT_MIX)
			rd_word = {20'h00000, cct_mix_ff};
		else if (S_AXI_ARADDR_I == REG_STATUS)
			rd_word = {21'h000000, strap_done_ff, range_hi_ff, id_st_ff != ID_IDLE, cool_is_2_ff,
				sync_seen_ff, ceil_sel_ff, day_act_ff, mode_ff};
		else if (S_AXI_ARADDR_I == REG_DIM)
			rd_word = {6'h00, aux_code_ff, 6'h00, dim_code_ff};
		else if (S_AXI_ARADDR_I == REG_LUX)
			rd_word = {16'h0000, lux_tgt_ff};
		else if (S_AXI_ARADDR_I == REG_SENS_X)
			rd_word = {16'h0000, sens_ff[0]};
		else if (S_AXI_ARADDR_I == REG_SENS_Y)
			rd_word = {16'h0000, sens_ff[1]};
		else if (S_AXI_ARADDR_I == REG_SENS_Z)
			rd_word = {16'h0000, sens_ff[2]};
		else
			rd_ok = 1'b0;
	end
	assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O  <= 32'h00000000;
			S_AXI_RRESP_O  <= RESP_OKAY;
		end else if (S_AXI_ARVALID_I && !S_AXI_RVALID_O) begin
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RDATA_O  <= rd_word;
			S_AXI_RRESP_O  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY_I) begin
			S_AXI_RVALID_O <= 1'b0;
		end
	end

	// result only ever moves as a whole word, so a read sees old or new
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			sens_ff[0] <= 16'h0000;
			sens_ff[1] <= 16'h0000;
			sens_ff[2] <= 16'h0000;
		end else if (SENSOR_DONE_I && SENSOR_CH_I != 2'b11) begin
			sens_ff[SENSOR_CH_I] <= SENSOR_RESULT_I;
		end
	end

	// strap is sampled once after reset release
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			mode_ff       <= MODE_ANALOG;
			strap_done_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			mode_ff       <= (MODE_STRAP_I == 2'b11) ? MODE_PWM3 : MODE_STRAP_I;
			strap_done_ff <= 1'b1;
		end
	end

	// input conditioning
	logic aux_digital;
	assign aux_digital = EXPANDER_PRESENT_I ? EXPANDER_AUX_DIG_I : ctrl_ff[CTRL_AUX_DIG];
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			range_hi_ff <= 1'b0;
			dim_code_ff <= 10'h000;
			aux_code_ff <= 10'h3FF;
			eff_dim_ff  <= 10'h000;
		end else begin
			range_hi_ff <= HIGH_VOLTAGE_SUPPLY_HIGH_I;
			dim_code_ff <= DIMMER_LEVEL_ADC_I[11:2];
			aux_code_ff <= aux_digital ? {10{AUX_LEVEL_I}} : AUX_ADC_I[11:2];
			eff_dim_ff  <= scale10(dim_code_ff, {1'b0, aux_code_ff} + 11'h001);
		end
	end
	assign DIM_RANGE_HIGH_O = range_hi_ff;
	assign MAINT_LUMEN_O    = EXPANDER_PRESENT_I ? EXPANDER_MAINT_I[0] : ctrl_ff[CTRL_LUMEN];
	assign MAINT_CCT_O      = EXPANDER_PRESENT_I ? EXPANDER_MAINT_I[1] : ctrl_ff[CTRL_CCT];

	// daylight target
	logic [9:0]  ceil_max;
	logic [9:0]  dim_ref_ff;
	logic [17:0] open_cnt_ff;
	logic [9:0]  dim_delta;
	always_comb begin
		ceil_max = 10'h000;
		case (ceil_sel_ff)
			3'd1: ceil_max = LUX_MAX_1;
			3'd2: ceil_max = LUX_MAX_2;
			3'd3: ceil_max = LUX_MAX_3;
			3'd4: ceil_max = LUX_MAX_4;
			default: ceil_max = 10'h000;
		endcase
	end
	assign dim_delta = (dim_code_ff > dim_ref_ff) ? dim_code_ff - dim_ref_ff : dim_ref_ff - dim_code_ff;
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			day_act_ff  <= 1'b0;
			ceil_sel_ff <= 3'd0;
		end else begin
			day_act_ff <= ALS_DETECTED_I && DAYLIGHT_ENABLE_PIN_I;
			if (!day_act_ff)
				ceil_sel_ff <= 3'd0;
			else if (LUX_CEILING_INPUT_I < CEIL_THR_1)
				ceil_sel_ff <= 3'd0;
			else if (LUX_CEILING_INPUT_I < CEIL_THR_2)
				ceil_sel_ff <= 3'd1;
			else if (LUX_CEILING_INPUT_I < CEIL_THR_3)
				ceil_sel_ff <= 3'd2;
			else if (LUX_CEILING_INPUT_I < CEIL_THR_4)
				ceil_sel_ff <= 3'd3;
			else
				ceil_sel_ff <= 3'd4;
		end
	end
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			dim_ref_ff  <= 10'h000;
			open_cnt_ff <= 18'h00000;
			lux_tgt_ff  <= 16'h0000;
		end else if (!day_act_ff) begin
			open_cnt_ff <= 18'h00000;
			dim_ref_ff  <= dim_code_ff;
		end else if (ceil_sel_ff != 3'd0) begin
			open_cnt_ff <= 18'h00000;
			dim_ref_ff  <= dim_code_ff;
			lux_tgt_ff  <= {6'h00, scale10(dim_code_ff, {1'b0, ceil_max})};
		end else if (open_cnt_ff != 18'h00000) begin
			open_cnt_ff <= open_cnt_ff - 18'h00001;
			if (open_cnt_ff == 18'h00001)
				lux_tgt_ff <= LUX_MEAS_I;
		end else if (dim_delta > DIM_MOVE_THR) begin
			dim_ref_ff  <= dim_code_ff;
			open_cnt_ff <= 18'(LOOP_OPEN_LEN);
		end
	end
	assign DAYLIGHT_ACTIVE_O = day_act_ff;
	assign LOOP_OPEN_O       = open_cnt_ff != 18'h00000;
	assign LUX_TARGET_O      = lux_tgt_ff;

	// string identification: light pwm2, hold pwm3 off and compare blue against red content
	logic [1:0] id_done_cnt_ff;
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			id_st_ff       <= ID_IDLE;
			id_done_cnt_ff <= 2'd0;
			cool_is_2_ff   <= 1'b1;
		end else begin
			case (id_st_ff)
				ID_IDLE: begin
					id_done_cnt_ff <= 2'd0;
					if (ctrl_ff[CTRL_ID_START])
						id_st_ff <= ID_LIGHT;
				end
				ID_LIGHT: begin
					// first result may straddle the switch-over, wait for a second one
					if (SENSOR_DONE_I && SENSOR_CH_I == 2'd2)
						id_done_cnt_ff <= id_done_cnt_ff + 2'd1;
					if (id_done_cnt_ff == 2'd2)
						id_st_ff <= ID_DECIDE;
				end
				ID_DECIDE: begin
					cool_is_2_ff <= sens_ff[2] > sens_ff[0];
					id_st_ff     <= ID_IDLE;
				end
				default: id_st_ff <= ID_IDLE;
			endcase
		end
	end

	// shared timebase
	logic [6:0]  presc_ff;
	logic [11:0] phase_ff;
	logic        realign;
	assign realign = sync_edge_ff && ctrl_ff[CTRL_SYNC_EN] && sync_seen_ff;
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			presc_ff <= 7'h00;
			phase_ff <= 12'h000;
		end else if (realign) begin
			presc_ff <= 7'h00;
			phase_ff <= 12'h000;
		end else if (presc_ff == 7'(PWM_PRESCALE - 1)) begin
			presc_ff <= 7'h00;
			phase_ff <= phase_ff + 12'h001;
		end else begin
			presc_ff <= presc_ff + 7'h01;
		end
	end

	// duty assignment per mode
	logic [11:0] dim_duty;
	logic [11:0] cool_share;
	logic [11:0] warm_share;
	logic [11:0] duty1;
	logic [11:0] duty2;
	logic [11:0] duty3;
	logic [11:0] cool_d;
	logic [11:0] warm_d;
	assign dim_duty   = duty_of(eff_dim_ff);
	assign cool_share = cct_mix_ff;
	assign warm_share = 12'hFFF - cct_mix_ff;
	always_comb begin
		cool_d = cool_share;
		warm_d = warm_share;
		if (mode_ff == MODE_TUNE2) begin
			cool_d = mix12(cool_share, dim_duty) ;
			warm_d = mix12(warm_share, dim_duty);
		end
		duty1 = 12'h000;
		duty2 = cool_is_2_ff ? cool_d : warm_d;
		duty3 = cool_is_2_ff ? warm_d : cool_d;
		if (mode_ff == MODE_PWM3)
			duty1 = dim_duty;
		if (!CONFIG_LOADED_I) begin
			duty2 = 12'h000;
			duty3 = 12'h000;
		end else if (id_st_ff != ID_IDLE) begin
			duty2 = 12'hFFF;
			duty3 = 12'h000;
		end
		if (!CONFIG_LOADED_I)
			duty1 = 12'h000;
	end
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n)
			ANALOG_DIM_O <= 12'h000;
		else if (mode_ff == MODE_ANALOG && CONFIG_LOADED_I)
			ANALOG_DIM_O <= dim_duty;
		else
			ANALOG_DIM_O <= 12'h000;
	end

	ldp_pwm_chan u_pwm1 (
		.clk_i    (CORE_CLK_I),
		.rst_n_i  (core_rst_n),
		.phase_i  (phase_ff),
		.offset_i (PHASE_OFS_1),
		.duty_i   (duty1),
		.pwm_o    (PWM1_O)
	);
	ldp_pwm_chan u_pwm2 (
		.clk_i    (CORE_CLK_I),
		.rst_n_i  (core_rst_n),
		.phase_i  (phase_ff),
		.offset_i (PHASE_OFS_2),
		.duty_i   (duty2),
		.pwm_o    (PWM2_O)
	);
	ldp_pwm_chan u_pwm3 (
		.clk_i    (CORE_CLK_I),
		.rst_n_i  (core_rst_n),
		.phase_i  (phase_ff),
		.offset_i (PHASE_OFS_3),
		.duty_i   (duty3),
		.pwm_o    (PWM3_O)
	);

	// progress indicator
	logic [25:0] blink_cnt_ff;
	logic        blink_ff;
	always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
		if (!core_rst_n) begin
			blink_cnt_ff <= 26'h0000000;
			blink_ff     <= 1'b0;
		end else if (PROG_ACTIVE_I) begin
			if (blink_cnt_ff >= 26'(BLINK_HALF_LEN - 1)) begin
				blink_cnt_ff <= 26'h0000000;
				blink_ff     <= !blink_ff;
			end else begin
				blink_cnt_ff <= blink_cnt_ff + 26'h0000001;
			end
		end else begin
			blink_cnt_ff <= 26'h0000000;
			blink_ff     <= PROG_DONE_I;
		end
	end
	assign PROGRESS_INDICATOR_OUTPUT_O = blink_ff;
endmodule // ldp_top
`default_nettype wire

//--- rtl/ldp_pkg.sv
// shared constants for the lighting dimming pwm controller
`default_nettype none
package ldp_pkg;
	localparam int unsigned CLK_HZ          = 250_000_000;
	localparam int unsigned PWM_FREQ_HZ     = 888;
	localparam int unsigned PWM_STEPS       = 4096;
	localparam int unsigned PWM_PRESCALE    = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
	localparam int unsigned SYNC_RESET_MS   = 100;
	localparam int unsigned SYNC_RESET_CYC  = (CLK_HZ / 1000) * SYNC_RESET_MS;
	localparam int unsigned LOOP_OPEN_US    = 1000;
	localparam int unsigned LOOP_OPEN_CYC   = (CLK_HZ / 1_000_000) * LOOP_OPEN_US;
	localparam int unsigned BLINK_HALF_MS   = 250;
	localparam int unsigned BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;
	// fixed phase offsets keep the three channels from rising together
	localparam logic [11:0] PHASE_OFS_1     = 12'h000;
	localparam logic [11:0] PHASE_OFS_2     = 12'h555;
	localparam logic [11:0] PHASE_OFS_3     = 12'hAAA;
	localparam logic [9:0]  DIM_MOVE_THR    = 10'h008;
	localparam logic [7:0]  CEIL_THR_1      = 8'h33;
	localparam logic [7:0]  CEIL_THR_2      = 8'h66;
	localparam logic [7:0]  CEIL_THR_3      = 8'h99;
	localparam logic [7:0]  CEIL_THR_4      = 8'hCC;
	localparam logic [9:0]  LUX_MAX_1       = 10'd100;
	localparam logic [9:0]  LUX_MAX_2       = 10'd250;
	localparam logic [9:0]  LUX_MAX_3       = 10'd500;
	localparam logic [9:0]  LUX_MAX_4       = 10'd1000;
	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_CCT_MIX     = 8'h04;
	localparam logic [7:0]  REG_STATUS      = 8'h08;
	localparam logic [7:0]  REG_DIM         = 8'h0C;
	localparam logic [7:0]  REG_LUX         = 8'h10;
	localparam logic [7:0]  REG_SENS_X      = 8'h14;
	localparam logic [7:0]  REG_SENS_Y      = 8'h18;
	localparam logic [7:0]  REG_SENS_Z      = 8'h1C;
	localparam int unsigned CTRL_AUX_DIG    = 0;
	localparam int unsigned CTRL_LUMEN      = 1;
	localparam int unsigned CTRL_CCT        = 2;
	localparam int unsigned CTRL_SYNC_EN    = 3;
	localparam int unsigned CTRL_ID_START   = 4;
	localparam logic [4:0]  CTRL_RESET      = 5'h08;
	localparam logic [11:0] CCT_MIX_RESET   = 12'h800;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
	typedef enum logic [1:0] {
		MODE_ANALOG  = 2'b00,
		MODE_PWM3    = 2'b01,
		MODE_TUNE2   = 2'b10
	} ldp_mode_e;
	typedef enum logic [1:0] {
		ID_IDLE   = 2'b00,
		ID_LIGHT  = 2'b01,
		ID_DECIDE = 2'b10
	} ldp_id_e;
endpackage
`default_nettype wire

//--- rtl/ldp_pwm_chan.sv
// one pwm channel running off the shared 12-bit timebase
`default_nettype none
module ldp_pwm_chan
	import ldp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [11:0] phase_i,
	input  wire logic [11:0] offset_i,
	input  wire logic [11:0] duty_i,
	output var  logic        pwm_o
);
	logic [11:0] local_phase;
	assign local_phase = phase_i - offset_i;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwm_o <= 1'b0;
		end else begin
			// full code stays high so 100 % is reachable
			pwm_o <= (duty_i == 12'hFFF) || (local_phase < duty_i);
		end
	end
endmodule // ldp_pwm_chan
`default_nettype wire

//--- bench/ldp_chk.sv
// concurrent checks on the controller ports, bound into the top
`default_nettype none
module ldp_chk
	import ldp_pkg::*;
#(
	parameter int unsigned RESET_HOLD_CYC = 200
)(
	input wire logic CORE_CLK_I, RESETN_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O,
	input wire logic S_AXI_BVALID_O, S_AXI_BREADY_I, HIGH_VOLTAGE_SUPPLY_HIGH_I, DIM_RANGE_HIGH_O,
	input wire logic ALS_DETECTED_I, DAYLIGHT_ENABLE_PIN_I, DAYLIGHT_ACTIVE_O, LOOP_OPEN_O,
	input wire logic SYNC_OR_RESET_PIN_I, FULL_RESET_O, PWM1_O, PWM2_O, PWM3_O,
	input wire logic PROG_ACTIVE_I, PROG_DONE_I, CONFIG_LOADED_I, PROGRESS_INDICATOR_OUTPUT_O,
	input wire logic [1:0] MODE_STRAP_I
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] low_cnt_ff;
	// pin watcher is not cleared by the full reset it causes
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			low_cnt_ff <= 32'h0;
		else if (SYNC_OR_RESET_PIN_I)
			low_cnt_ff <= 32'h0;
		else
			low_cnt_ff <= low_cnt_ff + 32'h1;
	end
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	a_bresp_stands:
		assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O) else $error("bvalid dropped");
	a_read_answer:
		assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O) else $error("read late");
	a_range_follows:
		assert property ($past(RESETN_I) && !$past(FULL_RESET_O) |-> DIM_RANGE_HIGH_O == $past(HIGH_VOLTAGE_SUPPLY_HIGH_I))
		else $error("range select wrong");
	a_daylight_gate:
		assert property (DAYLIGHT_ACTIVE_O |-> $past(ALS_DETECTED_I && DAYLIGHT_ENABLE_PIN_I)) else $error("daylight ungated");
	a_reset_hold:
		assert property (FULL_RESET_O |-> low_cnt_ff >= RESET_HOLD_CYC - 1) else $error("full reset too soon");
	a_loop_brief:
		assert property ($rose(LOOP_OPEN_O) |-> LOOP_OPEN_O [*8] ##[1:40] !LOOP_OPEN_O) else $error("loop open length");
	a_pwm_stagger:
		assert property ($countones({$rose(PWM1_O), $rose(PWM2_O), $rose(PWM3_O)}) < 2) else $error("pwm edges together");
	a_pwm1_idle:
		assert property (!MODE_STRAP_I[0] |-> !PWM1_O) else $error("first pwm active in mode 0 or 2");
	a_indicator_on:
		assert property ((PROG_DONE_I && !PROG_ACTIVE_I && CONFIG_LOADED_I) [*3] |-> PROGRESS_INDICATOR_OUTPUT_O)
		else $error("indicator not steady");
endmodule // ldp_chk
bind ldp_top ldp_chk #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) i_chk (.*);
`default_nettype wire

//--- bench/ldp_far_model.sv
// board side: sync pin with pull-up, mode strap and flash loader
`default_nettype none
module ldp_far_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       pull_low_i,
	input  wire logic [1:0] mode_i,
	output var  logic       pin_o,
	output var  logic [1:0] strap_o,
	output var  logic       loaded_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] wait_ff;
	// open pin floats up, so no sync unless pulled
	assign pin_o = !pull_low_i;
	assign strap_o = mode_i;
	// flash needs a few cycles to deliver setup
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			wait_ff <= 3'h0;
		else if (wait_ff != 3'h7)
			wait_ff <= wait_ff + 3'h1;
	end
	assign loaded_o = (wait_ff == 3'h7);
endmodule // ldp_far_model
`default_nettype wire

//--- bench/ldp_top_test.sv
// register and pin level bench for the dimming controller
`default_nettype none
module ldp_top_test;
	import ldp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic CORE_CLK_I, RESETN_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O;
	logic S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I;
	logic [7:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I, LUX_CEILING_INPUT_I;
	logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O;
	logic [3:0] S_AXI_WSTRB_I;
	logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, EXPANDER_MAINT_I, SENSOR_CH_I, MODE_STRAP_I, mode;
	logic [11:0] DIMMER_LEVEL_ADC_I, AUX_ADC_I, ANALOG_DIM_O;
	logic [15:0] LUX_MEAS_I, LUX_TARGET_O, SENSOR_RESULT_I;
	logic HIGH_VOLTAGE_SUPPLY_HIGH_I, DIM_RANGE_HIGH_O, AUX_LEVEL_I, EXPANDER_PRESENT_I, EXPANDER_AUX_DIG_I;
	logic MAINT_LUMEN_O, MAINT_CCT_O, ALS_DETECTED_I, DAYLIGHT_ENABLE_PIN_I, DAYLIGHT_ACTIVE_O, LOOP_OPEN_O;
	logic SENSOR_DONE_I, SYNC_OR_RESET_PIN_I, FULL_RESET_O, CONFIG_LOADED_I, PROG_ACTIVE_I, PROG_DONE_I;
	logic PROGRESS_INDICATOR_OUTPUT_O, PWM1_O, PWM2_O, PWM3_O, pull_low, fr_seen = 1'b0, v;
	int checks, mismatches, n, i, tg;
	int mx[4] = '{100, 250, 500, 1000};
	ldp_top #(.RESET_HOLD_CYC(200), .LOOP_OPEN_LEN(20), .BLINK_HALF_LEN(10)) i_dut (.*);
	ldp_far_model i_far (.clk_i(CORE_CLK_I), .rst_n_i(RESETN_I), .pull_low_i(pull_low), .mode_i(mode),
		.pin_o(SYNC_OR_RESET_PIN_I), .strap_o(MODE_STRAP_I), .loaded_o(CONFIG_LOADED_I));
	task automatic tick(input int k);
		repeat (k) @(posedge CORE_CLK_I);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrc(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1;
		w = 1;
		tick(1);
		S_AXI_AWADDR_I <= a;
		S_AXI_WDATA_I <= d;
		S_AXI_WSTRB_I <= 4'hF;
		{S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
		for (n = 0; n < 99; ) begin
			tick(1);
			if (aw && S_AXI_AWREADY_O) begin
				aw = 0;
				S_AXI_AWVALID_I <= 1'b0;
			end
			if (w && S_AXI_WREADY_O) begin
				w = 0;
				S_AXI_WVALID_I <= 1'b0;
			end
			if (S_AXI_BVALID_O) begin
				S_AXI_BREADY_I <= 1'b0;
				cmp(S_AXI_BRESP_O, a > REG_CCT_MIX ? RESP_SLVERR : RESP_OKAY);
				n = 99;
			end
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		tick(1);
		S_AXI_ARADDR_I <= a;
		{S_AXI_ARVALID_I, S_AXI_RREADY_I} <= 2'h3;
		for (n = 0; n < 99; ) begin
			tick(1);
			if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
				S_AXI_ARVALID_I <= 1'b0;
			if (S_AXI_RVALID_O) begin
				S_AXI_RREADY_I <= 1'b0;
				cmp(S_AXI_RDATA_O & m, e);
				cmp(S_AXI_RRESP_O, a > REG_SENS_Z ? RESP_SLVERR : RESP_OKAY);
				n = 99;
			end
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		CORE_CLK_I = 0;
		forever #2 CORE_CLK_I = ~CORE_CLK_I;
	end
	always @(posedge CORE_CLK_I) if (FULL_RESET_O) fr_seen <= 1'b1;
	initial begin
		tick(20000);
		mismatches++;
		end_of_test;
	end
	initial begin
		{RESETN_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} = '0;
		{SENSOR_DONE_I, HIGH_VOLTAGE_SUPPLY_HIGH_I, EXPANDER_PRESENT_I, ALS_DETECTED_I, pull_low} = '0;
		{DAYLIGHT_ENABLE_PIN_I, PROG_ACTIVE_I, PROG_DONE_I, AUX_LEVEL_I, EXPANDER_AUX_DIG_I} = '0;
		{S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I, S_AXI_WSTRB_I, LUX_CEILING_INPUT_I} = '0;
		{EXPANDER_MAINT_I, SENSOR_CH_I, SENSOR_RESULT_I, LUX_MEAS_I, DIMMER_LEVEL_ADC_I} = '0;
		AUX_ADC_I = 12'hFFF;
		mode = 2'h1;
		tick(20);
		RESETN_I <= 1'b1;
		tick(10);
		rdc(REG_CTRL, 32'h1F, {27'h0, CTRL_RESET});
		rdc(REG_CCT_MIX, 32'hFFF, {20'h0, CCT_MIX_RESET});
		rdc(REG_STATUS, 32'h3, 32'h1);
		rdc(8'hFC, 32'hFFFFFFFF, 32'h0);
		wrc(REG_STATUS, 32'h0);
		wrc(REG_CTRL, 32'h6);
		rdc(REG_CTRL, 32'h1F, 32'h6);
		cmp({MAINT_CCT_O, MAINT_LUMEN_O}, 2'h3);
		EXPANDER_PRESENT_I <= 1'b1;
		EXPANDER_MAINT_I <= 2'h1;
		tick(2);
		cmp({MAINT_CCT_O, MAINT_LUMEN_O}, 2'h1);
		for (i = 1; i >= 0; i--) begin
			HIGH_VOLTAGE_SUPPLY_HIGH_I <= i[0];
			tick(3);
			cmp(DIM_RANGE_HIGH_O, i);
			rdc(REG_STATUS, 32'h200, i << 9);
		end
		DIMMER_LEVEL_ADC_I <= 12'hABC;
		tick(3);
		rdc(REG_DIM, 32'h3FF03FF, 32'h3FF02AF);
		for (i = 0; i < 4; i++) begin
			SENSOR_CH_I <= i[1:0];
			SENSOR_RESULT_I <= 16'h1234 + i[15:0];
			SENSOR_DONE_I <= 1'b1;
			tick(1);
			SENSOR_DONE_I <= 1'b0;
			tick(1);
		end
		for (i = 0; i < 3; i++)
			rdc(REG_SENS_X + 8'(4 * i), 32'hFFFF, 32'h1234 + i);
		wrc(REG_CTRL, 32'h16);
		SENSOR_CH_I <= 2'h2;
		SENSOR_RESULT_I <= 16'h0;
		SENSOR_DONE_I <= 1'b1;
		tick(4);
		SENSOR_DONE_I <= 1'b0;
		rdc(REG_STATUS, 32'h180, 32'h0);
		ALS_DETECTED_I <= 1'b1;
		tick(3);
		cmp(DAYLIGHT_ACTIVE_O, 1'b0);
		DAYLIGHT_ENABLE_PIN_I <= 1'b1;
		tick(3);
		cmp(DAYLIGHT_ACTIVE_O, 1'b1);
		for (i = 1; i < 5; i++) begin
			LUX_CEILING_INPUT_I <= 8'(8'h33 * i + 8'h10);
			tick(6);
			rdc(REG_STATUS, 32'h38, i << 3);
			cmp(LUX_TARGET_O, 687 * mx[i - 1] / 1024);
		end
		LUX_CEILING_INPUT_I <= 8'h00;
		LUX_MEAS_I <= 16'h0321;
		tick(5);
		DIMMER_LEVEL_ADC_I <= 12'h400;
		for (i = 0; i < 50 && !LOOP_OPEN_O; i++) tick(1);
		cmp(LOOP_OPEN_O, 1'b1);
		for (i = 0; i < 50 && LOOP_OPEN_O; i++) tick(1);
		tick(3);
		cmp(LUX_TARGET_O, 16'h0321);
		pull_low <= 1'b1;
		tick(20);
		pull_low <= 1'b0;
		tick(5);
		rdc(REG_CTRL, 32'h1F, 32'h6);
		pull_low <= 1'b1;
		tick(230);
		pull_low <= 1'b0;
		tick(10);
		cmp(fr_seen, 1'b1);
		rdc(REG_CTRL, 32'h1F, {27'h0, CTRL_RESET});
		PROG_ACTIVE_I <= 1'b1;
		tick(2);
		v = PROGRESS_INDICATOR_OUTPUT_O;
		tg = 0;
		for (i = 0; i < 30; i++) begin
			tick(1);
			if (PROGRESS_INDICATOR_OUTPUT_O !== v) tg++;
			v = PROGRESS_INDICATOR_OUTPUT_O;
		end
		cmp(tg > 1, 1'b1);
		PROG_ACTIVE_I <= 1'b0;
		PROG_DONE_I <= 1'b1;
		tick(5);
		cmp(PROGRESS_INDICATOR_OUTPUT_O, 1'b1);
		RESETN_I <= 1'b0;
		mode <= 2'h0;
		DIMMER_LEVEL_ADC_I <= 12'hFFF;
		tick(3);
		RESETN_I <= 1'b1;
		tick(30);
		cmp(ANALOG_DIM_O, 12'hFFF);
		end_of_test;
	end
endmodule // ldp_top_test
`default_nettype wire
